// ### hdl/imp_pkg.sv
// package for the interrupt mask and priority controller
package imp_pkg;

	// apb register byte offsets
	localparam logic [7:0] OFS_SYSCTL = 8'h00;
	localparam logic [7:0] OFS_LEVEL  = 8'h04;
	localparam logic [7:0] OFS_ENABLE = 8'h08;
	localparam logic [7:0] OFS_STATUS = 8'h0C;
	localparam logic [7:0] OFS_MASK   = 8'h10;
	localparam logic [7:0] OFS_VECTOR = 8'h14;

	// field widths and reset values
	localparam int         NUM_REQ    = 12;
	localparam int         NUM_EVT    = 14;
	localparam int         NUM_STAT   = 3;
	localparam logic [1:0] MODE_RST   = 2'h0;
	localparam logic [1:0] MODE_ONE   = 2'h1;
	localparam logic [3:0] LEVEL_RST  = 4'h0;
	localparam logic [13:0] ENABLE_RST = 14'h0000;
	localparam logic [2:0] MASK_RST   = 3'h0;

	// status bit positions
	localparam int ST_ACCEPT = 0;
	localparam int ST_NMI    = 1;
	localparam int ST_ABRK   = 2;

	// priority level register bit positions
	localparam logic [1:0] LB_C1 = 2'h0;
	localparam logic [1:0] LB_B0 = 2'h1;
	localparam logic [1:0] LB_C3 = 2'h2;
	localparam logic [1:0] LB_C4 = 2'h3;

	// vectors of the always-accepted sources (arbitrary defaults)
	localparam logic [6:0] VEC_NMI  = 7'h07;
	localparam logic [6:0] VEC_ABRK = 7'h1B;

	// vector per request line, index 0 is highest default priority
	localparam logic [NUM_REQ-1:0][6:0] VEC_TAB = {
		7'h6F, 7'h6E, 7'h6D, 7'h6C, 7'h6B, 7'h6A,
		7'h64, 7'h63, 7'h61, 7'h60, 7'h5F, 7'h5C};

	// level bit that controls each request line
	localparam logic [NUM_REQ-1:0][1:0] LVL_SEL = {
		LB_C1, LB_C1, LB_C1, LB_C1, LB_C1, LB_C1,
		LB_B0, LB_B0, LB_B0, LB_B0, LB_C3, LB_C4};

	// peripheral event group, first field is the msb
	typedef struct packed {
		logic host_in3_full_irq;
		logic host_in2_full_irq;
		logic host_in1_full_irq;
		logic host_xfer_error_irq;
		logic host_in4_full_irq;
		logic host_out_empty_irq;
		logic kbd_b_first_edge_irq;
		logic kbd_b_tx_done_irq;
		logic kbd_a_first_edge_irq;
		logic kbd_a_tx_done_irq;
		logic kbd_b_rx_done_irq;
		logic kbd_a_rx_done_irq;
		logic i2c2_byte_done_irq;
		logic i2c0_byte_done_irq;
	} imp_src_t;

	// request presented to the cpu core
	typedef struct packed {
		logic        req;
		logic [6:0]  vec;
		logic [23:0] vaddr;
	} imp_cpu_t;

	// cpu condition register mask bits
	typedef struct packed {
		logic global_mask;
		logic user_mask_bit;
	} imp_ccr_t;

endpackage

// ### hdl/imp_ctrl.sv
// interrupt mask and priority controller with apb registers
//
// Summary of operation
// RL1: two control modes chosen by a two-bit mode field, 00 and 01.
// RL2: nmi and address break always accepted except during reset.
// RL3: mode 0 masks with the global bit only; user bit ignored.
// RL4: mode 1 masks in three levels from global, user and level bits.
// RL5: mode 1, global 1, user 0: nmi, break and level-1 accepted.
// RL6: mode 1, both mask bits 1: only nmi and break accepted.
// RL7: global mask 0: all enabled requests taken, level 1 first.
// RL8: each source level comes from its priority level register bit.
// RL9: ties at one level resolved by fixed order; winner gets a vector.
// RL10: losing requests stay pending for later arbitration.
// RL11: i2c channel 0 to vector 92, channel 2 to vector 95.
// RL12: keyboard receive a and b to vectors 96, 97, one level bit.
// RL13: keyboard transmit or first edge: vector 99 for a, 100 for b.
// RL14: host port vectors 106 to 111 in fixed priority order.
// RL15: reserved vectors are never generated.
// RL16: an event requests only while its enable bit is 1.
// RL17: cpu sets global mask on accepting in mode 0.
// RL18: cpu sets global and user mask on accepting in mode 1.
// RL19: vector address is four times the vector; modes 10, 11 act as 0.
`timescale 1ns/10ps
module imp_ctrl
	import imp_pkg::*;
(
	// clock and reset
	input  wire logic                clk_in,
	input  wire logic                rstn_in,
	// apb slave
	input  wire logic                psel_in,
	input  wire logic                penable_in,
	input  wire logic                pwrite_in,
	input  wire logic [7:0]          paddr_in,
	input  wire logic [31:0]         pwdata_in,
	output logic [31:0]              prdata_out,
	output logic                     pready_out,
	output logic                     pslverr_out,
	// interrupt sources
	input  wire imp_pkg::imp_src_t   src_in,
	input  wire logic                nmi_in,
	input  wire logic                abrk_in,
	// cpu side
	input  wire imp_pkg::imp_ccr_t   ccr_in,
	output imp_pkg::imp_cpu_t        cpu_out,
	// masked status interrupt
	output logic                     irq_out
);

	// registers
	logic [1:0]          system_control_reg;
	logic [3:0]          priority_level_reg;
	logic [NUM_EVT-1:0]  enable_reg;
	logic [NUM_STAT-1:0] status_reg;
	logic [NUM_STAT-1:0] status_next;
	logic [NUM_STAT-1:0] mask_reg;
	logic [31:0]         rdata_reg;
	logic [31:0]         rdata_next;
	logic [NUM_STAT-1:0] rd_clr_reg;
	logic [NUM_STAT-1:0] rd_clr_next;
	imp_cpu_t            cpu_reg;
	imp_cpu_t            cpu_next;
	logic                nmi_d_reg;
	logic                abrk_d_reg;

	// lowest set index, i.e. highest default priority
	function automatic logic [3:0] first_idx(input logic [NUM_REQ-1:0] v);
		logic [3:0] r;
		r = 4'h0;
		for (int i = NUM_REQ - 1; i >= 0; i--) begin
			if (v[i]) begin
				r = 4'(i);
			end
		end
		return r;
	endfunction

	// apb decode
	wire logic setup  = psel_in & ~penable_in;
	wire logic access = psel_in & penable_in;
	wire logic wr     = access & pwrite_in;
	wire logic hit_sysctl = paddr_in == OFS_SYSCTL;
	wire logic hit_level  = paddr_in == OFS_LEVEL;
	wire logic hit_enable = paddr_in == OFS_ENABLE;
	wire logic hit_status = paddr_in == OFS_STATUS;
	wire logic hit_mask   = paddr_in == OFS_MASK;
	wire logic hit_vector = paddr_in == OFS_VECTOR;
	wire logic mapped = hit_sysctl | hit_level | hit_enable |
		hit_status | hit_mask | hit_vector;

	// zero wait states; unmapped addresses answer with an error
	assign pready_out  = 1'b1;
	assign pslverr_out = access & ~mapped;
	assign prdata_out  = rdata_reg;

	// read data is latched in setup so the access edge sees stable data
	assign rdata_next =
		!setup     ? rdata_reg :
		hit_sysctl ? {30'h0, system_control_reg} :
		hit_level  ? {28'h0, priority_level_reg} :
		hit_enable ? {18'h0, enable_reg} :
		hit_status ? {29'h0, status_reg} :
		hit_mask   ? {29'h0, mask_reg} :
		hit_vector ? {24'h0, cpu_reg.req, cpu_reg.vec} :
		32'h0;
	assign rd_clr_next = (setup & hit_status & ~pwrite_in) ? status_reg :
		(setup ? {NUM_STAT{1'b0}} : rd_clr_reg);

	// mode decode; reserved codes fall back to mode 0
	wire logic irq_mode_sel_hi = system_control_reg[1];
	wire logic irq_mode_sel_lo = system_control_reg[0];
	wire logic mode_one = {irq_mode_sel_hi, irq_mode_sel_lo} == MODE_ONE; // see RL1, RL19

	// only enabled events make requests
	wire imp_src_t gated = src_in & imp_src_t'(enable_reg); // see RL16

	// request lines in default priority order
	wire logic [NUM_REQ-1:0] req = {
		gated.host_in3_full_irq,
		gated.host_in2_full_irq,
		gated.host_in1_full_irq,
		gated.host_xfer_error_irq,
		gated.host_in4_full_irq,
		gated.host_out_empty_irq,                              // see RL14
		gated.kbd_b_tx_done_irq | gated.kbd_b_first_edge_irq,
		gated.kbd_a_tx_done_irq | gated.kbd_a_first_edge_irq,  // see RL13
		gated.kbd_b_rx_done_irq,
		gated.kbd_a_rx_done_irq,                               // see RL12
		gated.i2c2_byte_done_irq,
		gated.i2c0_byte_done_irq};                             // see RL11

	// control level of each line from its level bit
	logic [NUM_REQ-1:0] level_one;
	always_comb begin
		for (int i = 0; i < NUM_REQ; i++) begin
			level_one[i] = priority_level_reg[LVL_SEL[i]]; // see RL8
		end
	end

	// mask gates: mode 0 ignores the user bit
	wire logic allow_one = mode_one ?
		~(ccr_in.global_mask & ccr_in.user_mask_bit) : // see RL4, RL5, RL6
		~ccr_in.global_mask;                           // see RL3
	wire logic allow_zero = ~ccr_in.global_mask;       // see RL7

	wire logic [NUM_REQ-1:0] cand_one  = req & level_one & {NUM_REQ{allow_one}};
	wire logic [NUM_REQ-1:0] cand_zero = req & ~level_one & {NUM_REQ{allow_zero}};
	wire logic [3:0] win_one  = first_idx(cand_one);  // see RL9
	wire logic [3:0] win_zero = first_idx(cand_zero); // see RL9

	// order: nmi, level 1, address break, level 0; losers stay requesting
	always_comb begin
		cpu_next = '0;
		if (nmi_in) begin
			cpu_next.req = 1'b1;
			cpu_next.vec = VEC_NMI; // see RL2
		end else if (|cand_one) begin
			cpu_next.req = 1'b1;
			cpu_next.vec = VEC_TAB[win_one]; // see RL7, RL10, RL15
		end else if (abrk_in) begin
			cpu_next.req = 1'b1;
			cpu_next.vec = VEC_ABRK; // see RL2
		end else if (|cand_zero) begin
			cpu_next.req = 1'b1;
			cpu_next.vec = VEC_TAB[win_zero]; // see RL10, RL15
		end
		cpu_next.vaddr = {15'h0, cpu_next.vec, 2'h0}; // see RL19
	end
	assign cpu_out = cpu_reg;

	// sticky events; a new event wins over a read clear
	wire logic [NUM_STAT-1:0] evt;
	assign evt[ST_ACCEPT] = cpu_next.req & ~cpu_reg.req;
	assign evt[ST_NMI]    = nmi_in & ~nmi_d_reg;
	assign evt[ST_ABRK]   = abrk_in & ~abrk_d_reg;
	wire logic rd_status = access & ~pwrite_in & hit_status;
	assign status_next = (status_reg & ~(rd_status ? rd_clr_reg : {NUM_STAT{1'b0}})) | evt;
	assign irq_out = |(status_reg & mask_reg);

	// register writes take effect at the access edge
	always_ff @(posedge clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			system_control_reg <= MODE_RST;
			priority_level_reg <= LEVEL_RST;
			enable_reg         <= ENABLE_RST;
			mask_reg           <= MASK_RST;
		end else if (wr) begin
			if (hit_sysctl) begin
				system_control_reg <= pwdata_in[1:0];
			end
			if (hit_level) begin
				priority_level_reg <= pwdata_in[3:0];
			end
			if (hit_enable) begin
				enable_reg <= pwdata_in[NUM_EVT-1:0];
			end
			if (hit_mask) begin
				mask_reg <= pwdata_in[NUM_STAT-1:0];
			end
		end
	end

	// state and outputs; reset leaves no request toward the cpu
	always_ff @(posedge clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			status_reg <= '0;
			rdata_reg  <= '0;
			rd_clr_reg <= '0;
			cpu_reg    <= '0;
			nmi_d_reg  <= 1'b0;
			abrk_d_reg <= 1'b0;
		end else begin
			status_reg <= status_next;
			rdata_reg  <= rdata_next;
			rd_clr_reg <= rd_clr_next;
			cpu_reg    <= cpu_next; // see RL2
			nmi_d_reg  <= nmi_in;
			abrk_d_reg <= abrk_in;
		end
	end

endmodule

// ### bench/imp_ctrl_props.sv
// assertions on the ports of the mask and priority controller
`timescale 1ns/10ps
module imp_ctrl_props
	import imp_pkg::*;
(
	// clock and reset
	input  wire logic              clk_in,
	input  wire logic              rstn_in,
	// observed ports
	input  wire logic              psel_in,
	input  wire logic              penable_in,
	input  wire logic [7:0]        paddr_in,
	input  wire logic              pslverr_out,
	input  wire imp_pkg::imp_src_t src_in,
	input  wire logic              nmi_in,
	input  wire logic              abrk_in,
	input  wire imp_pkg::imp_ccr_t ccr_in,
	input  wire imp_pkg::imp_cpu_t cpu_out
);
	default clocking @(posedge clk_in); endclocking
	default disable iff (!rstn_in);
	wire quiet = !nmi_in && !abrk_in;
	wire apb_idle = !psel_in;
	nmi_first_a: assert property (nmi_in |=> cpu_out.req && cpu_out.vec == VEC_NMI)
		else $error("nmi request not presented");
	brk_taken_a: assert property (abrk_in && !nmi_in && ccr_in == 2'h3 |=> cpu_out.vec == VEC_ABRK)
		else $error("address break not presented");
	all_masked_a: assert property (quiet && ccr_in == 2'h3 |=> !cpu_out.req)
		else $error("masked request presented");
	no_source_a: assert property (quiet && src_in == '0 |=> !cpu_out.req)
		else $error("request without a source");
	vec_addr_a: assert property (cpu_out.req |-> cpu_out.vaddr == {15'h0000, cpu_out.vec, 2'h0})
		else $error("vector address not four times vector");
	rsvd_vec_a: assert property (cpu_out.req |-> !(cpu_out.vec inside {7'h5D, 7'h5E, 7'h62,
		[7'h65:7'h69], [7'h70:7'h7F]}))
		else $error("reserved vector generated");
	// sources hold their own pending state, so an unchanged source must keep asking
	held_req_a: assert property (cpu_out.req && $stable(src_in) && $stable(ccr_in) && quiet && $past(quiet)
		&& apb_idle && $past(apb_idle) |=> cpu_out.req)
		else $error("pending request dropped");
	unmapped_a: assert property (psel_in && penable_in && paddr_in > 8'h14 |-> pslverr_out)
		else $error("unmapped access not refused");
	cover property (nmi_in ##1 cpu_out.req);
	cover property (abrk_in && ccr_in == 2'h3);
	cover property ($rose(cpu_out.req));
endmodule

bind imp_ctrl imp_ctrl_props i_props (.clk_in(clk_in), .rstn_in(rstn_in), .psel_in(psel_in),
	.penable_in(penable_in), .paddr_in(paddr_in), .pslverr_out(pslverr_out), .src_in(src_in),
	.nmi_in(nmi_in), .abrk_in(abrk_in), .ccr_in(ccr_in), .cpu_out(cpu_out));

// ### bench/imp_cpu_model.sv
// cpu core model that raises its own mask bits on taking a request
`timescale 1ns/10ps
module imp_cpu_model
	import imp_pkg::*;
(
	// clock and reset
	input  wire logic              clk_in,
	input  wire logic              rstn_in,
	// controller side and bench control
	input  wire imp_pkg::imp_cpu_t cpu_in,
	input  wire logic              take_in,
	input  wire logic              mode1_in,
	input  wire imp_pkg::imp_ccr_t ccr_set_in,
	output imp_pkg::imp_ccr_t      ccr_out
);
	// while not taking, the mask bits follow the bench so tests can set them directly
	always_ff @(posedge clk_in or negedge rstn_in) begin
		if (!rstn_in)
			ccr_out <= '0;
		else if (take_in && cpu_in.req)
			ccr_out <= {1'b1, mode1_in};
		else if (!take_in)
			ccr_out <= ccr_set_in;
	end
endmodule

// ### bench/interrupt_mask_priority_control_test.sv
// self-checking bench for the interrupt mask and priority controller
`timescale 1ns/10ps
module interrupt_mask_priority_control_test;
	import imp_pkg::*;
	logic       clk_in = 0, rstn_in = 0, psel = 0, pen = 0, pwr = 0, nmi = 0, abrk = 0, take = 0, mode1 = 0;
	logic [7:0] paddr = '0;
	logic [31:0] pwdata = '0, prdata, rd;
	logic       pready, pslverr, irq, err;
	imp_src_t   src = '0;
	imp_ccr_t   cpu_condition_reg, ccr_set = '0;
	imp_cpu_t   cpu;
	int         miscompares = 0, samples_checked = 0, cyc = 0;
	logic [6:0] vt [14] = '{7'h5C, 7'h5F, 7'h60, 7'h61, 7'h63, 7'h63, 7'h64, 7'h64,
		7'h6A, 7'h6B, 7'h6C, 7'h6D, 7'h6E, 7'h6F};
	always #20 clk_in = ~clk_in;
	imp_ctrl i_dut (.clk_in(clk_in), .rstn_in(rstn_in), .psel_in(psel), .penable_in(pen), .pwrite_in(pwr),
		.paddr_in(paddr), .pwdata_in(pwdata), .prdata_out(prdata), .pready_out(pready), .pslverr_out(pslverr),
		.src_in(src), .nmi_in(nmi), .abrk_in(abrk), .ccr_in(cpu_condition_reg), .cpu_out(cpu), .irq_out(irq));
	imp_cpu_model i_cpu (.clk_in(clk_in), .rstn_in(rstn_in), .cpu_in(cpu), .take_in(take), .mode1_in(mode1),
		.ccr_set_in(ccr_set), .ccr_out(cpu_condition_reg));
	task automatic finish_test;
		$display("checked %0d mismatches %0d", samples_checked, miscompares);
		if (miscompares == 0 && samples_checked > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	always @(posedge clk_in) begin
		cyc++;
		if (cyc == 3000) begin
			miscompares++;
			finish_test();
		end
	end
	task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			miscompares++;
			$display("Error %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk_in);
		psel <= 1'b1;
		pwr <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk_in);
		pen <= 1'b1;
		do @(posedge clk_in); while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		pen <= 1'b0;
	endtask
	task automatic settle;
		repeat (3) @(posedge clk_in);
		@(negedge clk_in);
	endtask
	task automatic put(input imp_src_t s, input logic n, input logic b, input imp_ccr_t c);
		@(posedge clk_in);
		src <= s;
		nmi <= n;
		abrk <= b;
		ccr_set <= c;
		settle();
	endtask
	task automatic see(input logic r, input logic [6:0] v);
		chk("request", {31'h0, cpu.req}, {31'h0, r});
		if (r) begin
			chk("vector", {25'h0, cpu.vec}, {25'h0, v});
			chk("vector address", {8'h00, cpu.vaddr}, {8'h00, 15'h0000, v, 2'h0});
		end
	endtask
	initial begin
		repeat (2) @(posedge clk_in);
		rstn_in <= 1'b1;
		for (int a = 0; a < 28; a += 4) begin
			xfer(1'b0, 8'(a), 32'h0);
			chk("reset value", rd, 32'h0);
			chk("slave error", {31'h0, err}, {31'h0, a == 24});
		end
		$display("reset test done");
		xfer(1'b1, OFS_ENABLE, 32'h0000_3FFE);
		put(14'h0001, 1'b0, 1'b0, 2'h0);
		see(1'b0, 7'h00);
		xfer(1'b1, OFS_ENABLE, 32'h0000_3FFF);
		for (int i = 0; i < 14; i++) begin
			put(imp_src_t'(14'h0001 << i), 1'b0, 1'b0, 2'h0);
			see(1'b1, vt[i]);
		end
		$display("vector test done");
		put(14'h3FFF, 1'b0, 1'b0, 2'h0);
		see(1'b1, 7'h5C);
		put(14'h3FFE, 1'b0, 1'b0, 2'h0);
		see(1'b1, 7'h5F);
		xfer(1'b1, OFS_LEVEL, 32'h1);
		put(14'h3FFF, 1'b0, 1'b0, 2'h0);
		see(1'b1, 7'h6A);
		for (int m = 0; m < 4; m++) begin
			xfer(1'b1, OFS_SYSCTL, 32'(m));
			put(14'h3FFF, 1'b0, 1'b0, 2'h2);
			see(m == 1, 7'h6A);
		end
		xfer(1'b1, OFS_SYSCTL, 32'h1);
		put(14'h3FFF, 1'b0, 1'b0, 2'h3);
		see(1'b0, 7'h00);
		put(14'h3FFF, 1'b0, 1'b1, 2'h3);
		see(1'b1, VEC_ABRK);
		put(14'h3FFF, 1'b1, 1'b1, 2'h3);
		see(1'b1, VEC_NMI);
		xfer(1'b1, OFS_LEVEL, 32'h0);
		put(14'h3FFF, 1'b0, 1'b0, 2'h2);
		see(1'b0, 7'h00);
		xfer(1'b1, OFS_LEVEL, 32'h8);
		put(14'h3FFF, 1'b0, 1'b0, 2'h2);
		see(1'b1, 7'h5C);
		xfer(1'b1, OFS_LEVEL, 32'h0);
		$display("priority test done");
		for (int m = 0; m < 2; m++) begin
			xfer(1'b1, OFS_SYSCTL, 32'(m));
			put('0, 1'b0, 1'b0, 2'h0);
			@(posedge clk_in);
			take <= 1'b1;
			mode1 <= m[0];
			put(14'h0001, 1'b0, 1'b0, 2'h0);
			settle();
			see(1'b0, 7'h00);
			chk("mask bits", {30'h0, cpu_condition_reg}, {30'h0, 1'b1, m[0]});
			@(posedge clk_in);
			take <= 1'b0;
		end
		$display("cpu test done");
		xfer(1'b1, OFS_MASK, 32'h7);
		put('0, 1'b0, 1'b0, 2'h0);
		xfer(1'b0, OFS_STATUS, 32'h0);
		put(14'h0001, 1'b0, 1'b0, 2'h0);
		chk("irq raised", {31'h0, irq}, 32'h1);
		xfer(1'b0, OFS_STATUS, 32'h0);
		chk("status", rd, 32'h1);
		settle();
		chk("irq cleared", {31'h0, irq}, 32'h0);
		xfer(1'b1, OFS_MASK, 32'h0);
		put(14'h0001, 1'b1, 1'b0, 2'h0);
		chk("irq masked", {31'h0, irq}, 32'h0);
		xfer(1'b0, OFS_STATUS, 32'h0);
		chk("status", rd, 32'h2);
		xfer(1'b0, OFS_VECTOR, 32'h0);
		chk("vector reg", rd, {24'h0, 1'b1, VEC_NMI});
		$display("irq test done");
		finish_test();
	end
endmodule
